/* sim/lnbi_checker.sv */
// wire-level checks of the two-wire link between host end and device end
`default_nettype none
module lnbi_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic power_good,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   logic scl_q;
   logic sda_q;
   logic first;
   logic rd;
   logic nacked;
   logic hi;
   logic [3:0] cnt;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // scl held high past its rising cycle
   assign hi = scl && scl_q;
   // bit counter framed by start conditions, direction and nack capture
   always_ff @(posedge clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (!rst_b) begin
         first <= 1'b0;
         rd <= 1'b0;
         nacked <= 1'b0;
         cnt <= 4'h0;
      end else if (scl && scl_q && sda_q && !sda) begin
         first <= 1'b1;
         nacked <= 1'b0;
         cnt <= 4'h0;
      end else if (scl && !scl_q) begin
         cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
         if (cnt == 4'h9) first <= 1'b0;
         if (first && cnt == 4'h7) rd <= sda;
         if (cnt == 4'h8 && sda && (first || rd)) nacked <= 1'b1;
      end
   end
   sequence s_lock;
      !power_good [*8];
   endsequence
   sequence s_read_bit;
      hi && !first && rd && !nacked && cnt inside {[4'h1:4'h8]};
   endsequence
   a_lockout_silent: assert property (s_lock |-> !dev_sda_oe)
      else $error("device drove sda during lockout");
   a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device changed sda while scl high");
   a_no_clash: assert property (hi && dev_sda_oe |-> !host_sda_oe)
      else $error("host and device drove sda together");
   a_addr_quiet: assert property (hi && first && cnt != 4'h9 |-> !dev_sda_oe)
      else $error("device drove sda inside address byte");
   a_write_quiet: assert property (hi && !first && !rd && cnt != 4'h9 |-> !dev_sda_oe)
      else $error("device drove sda on write data bit");
   a_read_ackslot: assert property (hi && !first && rd && cnt == 4'h9 |-> !dev_sda_oe)
      else $error("device drove sda in master ack slot");
   a_nack_release: assert property (nacked |-> !dev_sda_oe)
      else $error("device drove sda after nack");
   a_read_drives: assert property (s_read_bit ##0 !sda |-> dev_sda_oe)
      else $error("read data low without device drive");
endmodule
`default_nettype wire

/* sim/lnbi_test.sv */
// self-checking bench: host end and device end joined over the link
`include "lnbi_map.svh"
`default_nettype none
module lnbi_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QTR = 12;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic power_good = 1'b1;
   logic [1:0] strap = 2'h0;
   logic [6:0] flags = 7'h00;
   logic [1:0] pins = 2'h0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, ch1_en, ch2_en, ready;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, got, st;
   logic [39:0] sys_cfg;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   // strap, fault flags, threshold pins, expected first two bytes
   logic [26:0] rows [4] = '{27'h020_2002, 27'h3e1_241e, 27'h49e_2008, 27'h64b_2404};
   lnbi_if lnbi_if_i ();
   lnbi_host #(.QTR(QTR)) lnbi_host_i (.clk(clk), .rst_b(rst_b), .bus(lnbi_if_i),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
   lnbi_device lnbi_device_i (.clk(clk), .rst_b(rst_b), .bus(lnbi_if_i),
      .power_good(power_good), .slave_addr_strap_lsb(strap[0]),
      .slave_addr_strap_msb(strap[1]), .overtemp_fault_flag(flags[6]),
      .ch1_tone_present_flag(flags[5]), .ch1_voltage_fault_flag(flags[4]),
      .ch1_current_fault_flag(flags[3]), .ch2_tone_present_flag(flags[2]),
      .ch2_voltage_fault_flag(flags[1]), .ch2_current_fault_flag(flags[0]),
      .ch1_tone_threshold_pin(pins[0]), .ch2_tone_threshold_pin(pins[1]),
      .sys_cfg(sys_cfg), .ch1_output_enable(ch1_en), .ch2_output_enable(ch2_en),
      .interface_ready(ready));
   lnbi_checker lnbi_checker_i (.clk(clk), .rst_b(rst_b), .power_good(power_good),
      .scl(lnbi_if_i.scl), .sda(lnbi_if_i.sda), .host_sda_oe(lnbi_if_i.host_sda_oe),
      .dev_sda_oe(lnbi_if_i.dev_sda_oe));
   // clock generation
   always #12.5 clk = ~clk;
   task automatic give_verdict;
      if (failures == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         failures = failures + 1;
         give_verdict();
      end
   end
   task automatic report(input logic [39:0] g, input logic [39:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic check_word(input logic [31:0] g, input logic [31:0] e);
      report({8'h00, g}, {8'h00, e});
   endtask
   task automatic check_cfg(input logic [39:0] g, input logic [39:0] e);
      report(g, e);
   endtask
   task automatic check_bit(input logic g, input logic e);
      report({39'h0, g}, {39'h0, e});
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      @(posedge clk);
   endtask
   // one serial transfer: load data, start, wait out busy, fetch read data
   task automatic xfer(input logic [31:0] cmd, input logic [31:0] wd);
      axi_wr(`LNBI_OFS_WDATA, wd, rs);
      axi_wr(`LNBI_OFS_CMD, cmd, rs);
      st = 32'h0000_0000;
      while (st[0] !== 1'b1) axi_rd(`LNBI_OFS_STAT, st, rs);
      while (st[0] !== 1'b0) axi_rd(`LNBI_OFS_STAT, st, rs);
      axi_rd(`LNBI_OFS_RDATA, got, rs);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      check_cfg(sys_cfg, 40'h00_0000_0000);
      check_bit(ch1_en, 1'b0);
      check_bit(ch2_en, 1'b0);
      check_bit(ready, 1'b1);
      for (int i = 0; i < 4; i++) begin
         {strap, flags, pins} <= rows[i][26:16];
         repeat (8) @(posedge clk);
         xfer(32'h0000_0388 | {30'h0, rows[i][26:25]}, 32'h0000_0000);
         check_word(got, {16'h6040, rows[i][15:0]});
         check_word(st, 32'h0000_0000);
      end
      xfer(32'h0000_0388, 32'h0000_0000);
      check_word(st, 32'h0000_0002);
      flags <= 7'h00;
      pins <= 2'h0;
      xfer(32'h0000_030b, 32'hf070_241f);
      check_cfg(sys_cfg, 40'h80_0008_0080);
      check_bit(ch1_en, 1'b1);
      check_bit(ch2_en, 1'b1);
      xfer(32'h0000_038b, 32'h0000_0000);
      check_word(got, 32'h7040_2400);
      power_good <= 1'b0;
      repeat (8) @(posedge clk);
      check_cfg(sys_cfg, 40'h80_0008_0000);
      check_bit(ready, 1'b0);
      xfer(32'h0000_038b, 32'h0000_0000);
      check_word(st, 32'h0000_0002);
      power_good <= 1'b1;
      repeat (8) @(posedge clk);
      xfer(32'h0000_030b, 32'h0000_0024);
      xfer(32'h0000_038b, 32'h0000_0000);
      check_word(got, 32'h7040_2400);
      // interrupt: clear, masked event, enable, clear
      axi_wr(`LNBI_OFS_INTCLR, 32'h0000_0003, rs);
      xfer(32'h0000_008b, 32'h0000_0000);
      check_bit(irq, 1'b0);
      axi_rd(`LNBI_OFS_INTST, got, rs);
      check_word(got, 32'h0000_0001);
      axi_wr(`LNBI_OFS_INTEN, 32'h0000_0001, rs);
      repeat (2) @(posedge clk);
      check_bit(irq, 1'b1);
      axi_wr(`LNBI_OFS_INTCLR, 32'h0000_0001, rs);
      repeat (2) @(posedge clk);
      check_bit(irq, 1'b0);
      // unmapped offset answers with slave error
      axi_rd(8'h1c, got, rs);
      check_word({30'h0, rs}, 32'h0000_0002);
      axi_wr(8'h1c, 32'h0000_0000, rs);
      check_word({30'h0, rs}, 32'h0000_0002);
      give_verdict();
   end
endmodule
`default_nettype wire

/* verilog/lnbi_device.sv */
// device end: serial slave with system registers and power-good gating
`include "lnbi_map.svh"
`default_nettype none
module lnbi_device (
   input wire logic clk,
   input wire logic rst_b,
   lnbi_if.dev bus,
   input wire logic power_good,
   input wire logic slave_addr_strap_lsb,
   input wire logic slave_addr_strap_msb,
   input wire logic ch1_current_fault_flag,
   input wire logic ch1_voltage_fault_flag,
   input wire logic ch1_tone_present_flag,
   input wire logic ch2_current_fault_flag,
   input wire logic ch2_voltage_fault_flag,
   input wire logic ch2_tone_present_flag,
   input wire logic overtemp_fault_flag,
   input wire logic ch1_tone_threshold_pin,
   input wire logic ch2_tone_threshold_pin,
   output logic [39:0] sys_cfg,
   output logic ch1_output_enable,
   output logic ch2_output_enable,
   output logic interface_ready
);
   localparam logic [7:0][4:0] WMASK = `LNBI_WMASK;
   lnbi_pkg::lnbi_dev_type r;
   lnbi_pkg::lnbi_dev_type nx;
   logic [`LNBI_NSYNC-1:0] raw;
   logic [`LNBI_NSYNC-1:0] next_filt;
   logic [7:0][4:0] ro;
   logic [7:0][7:0] rd_bytes;
   logic scl_f;
   logic sda_f;
   logic pg;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic match;
   logic [2:0] sel;
   // every pin input, in synchroniser order
   assign raw = {ch2_tone_threshold_pin, ch1_tone_threshold_pin, overtemp_fault_flag,
      ch2_tone_present_flag, ch2_voltage_fault_flag, ch2_current_fault_flag,
      ch1_tone_present_flag, ch1_voltage_fault_flag, ch1_current_fault_flag,
      slave_addr_strap_msb, slave_addr_strap_lsb, power_good, bus.sda, bus.scl};
   // a change counts once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < `LNBI_NSYNC; gi++) begin : g_filt
         assign next_filt[gi] = (r.s2[gi] == r.s3[gi]) ? r.s2[gi] : r.filt[gi];
      end
   endgenerate
   assign scl_f = r.filt[0];
   assign sda_f = r.filt[1];
   assign pg = r.filt[2];
   // bus events seen on the filtered lines
   assign rise = scl_f & ~r.scl_q;
   assign fall = ~scl_f & r.scl_q;
   assign start = scl_f & r.scl_q & r.sda_q & ~sda_f;
   assign stop = scl_f & r.scl_q & ~r.sda_q & sda_f;
   assign match = (r.sh[7:1] == {`LNBI_ADDR_UPPER, r.filt[4:3]});
   assign sel = r.sh[7:5];
   // live read-only fields
   always_comb begin
      ro = '0;
      ro[`LNBI_SEL_STATUS1][`LNBI_OVERTEMP_BIT] = r.filt[11];
      ro[`LNBI_SEL_STATUS1][`LNBI_TONE_BIT] = r.filt[7];
      ro[`LNBI_SEL_STATUS1][`LNBI_VOLT_BIT] = r.filt[6];
      ro[`LNBI_SEL_STATUS1][`LNBI_CUR_BIT] = r.filt[5];
      ro[`LNBI_SEL_STATUS2][`LNBI_TONE_BIT] = r.filt[10];
      ro[`LNBI_SEL_STATUS2][`LNBI_VOLT_BIT] = r.filt[9];
      ro[`LNBI_SEL_STATUS2][`LNBI_CUR_BIT] = r.filt[8];
      ro[`LNBI_SEL_TONE1][`LNBI_TTH_BIT] = r.filt[12];
      ro[`LNBI_SEL_TONE2][`LNBI_TTH_BIT] = r.filt[13];
   end
   // read-back image: select code above the five data bits
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rd
         assign rd_bytes[gi] = {3'(gi), (r.regs[gi] & WMASK[gi]) | ro[gi]};
      end
   endgenerate
   // bus slave sequencing
   always_comb begin
      nx = r;
      nx.s1 = raw;
      nx.s2 = r.s1;
      nx.s3 = r.s2;
      nx.filt = next_filt;
      nx.scl_q = scl_f;
      nx.sda_q = sda_f;
      case (r.state)
         lnbi_pkg::D_IDLE: ;
         lnbi_pkg::D_ADDR: begin
            if (rise) begin
               nx.sh = {r.sh[6:0], sda_f};
               nx.cnt = r.cnt + 4'h1;
            end
            if (fall && r.cnt == 4'h8) begin
               nx.cnt = 4'h0;
               if (match) begin
                  nx.oe = 1'b1;
                  nx.rw = r.sh[0];
                  nx.ptr = 3'h0;
                  nx.state = lnbi_pkg::D_AACK;
               end else begin
                  nx.state = lnbi_pkg::D_IDLE;
               end
            end
         end
         lnbi_pkg::D_AACK: begin
            if (fall) begin
               if (r.rw) begin
                  nx.sh = rd_bytes[r.ptr];
                  nx.oe = ~rd_bytes[r.ptr][7];
                  nx.state = lnbi_pkg::D_RDAT;
               end else begin
                  nx.oe = 1'b0;
                  nx.state = lnbi_pkg::D_WDAT;
               end
            end
         end
         lnbi_pkg::D_RDAT: begin
            if (rise) begin
               nx.cnt = r.cnt + 4'h1;
            end
            if (fall) begin
               if (r.cnt == 4'h8) begin
                  nx.oe = 1'b0;
                  nx.cnt = 4'h0;
                  nx.state = lnbi_pkg::D_MACK;
               end else begin
                  nx.sh = {r.sh[6:0], 1'b0};
                  nx.oe = ~r.sh[6];
               end
            end
         end
         lnbi_pkg::D_MACK: begin
            if (rise) begin
               nx.mack = ~sda_f;
            end
            if (fall) begin
               if (r.mack) begin
                  nx.ptr = r.ptr + 3'h1;
                  nx.sh = rd_bytes[nx.ptr];
                  nx.oe = ~rd_bytes[nx.ptr][7];
                  nx.state = lnbi_pkg::D_RDAT;
               end else begin
                  nx.state = lnbi_pkg::D_IDLE;
               end
            end
         end
         lnbi_pkg::D_WDAT: begin
            if (rise) begin
               nx.sh = {r.sh[6:0], sda_f};
               nx.cnt = r.cnt + 4'h1;
            end
            if (fall && r.cnt == 4'h8) begin
               nx.regs[sel] = (r.regs[sel] & ~WMASK[sel]) | (r.sh[4:0] & WMASK[sel]);
               nx.cnt = 4'h0;
               nx.oe = 1'b1;
               nx.state = lnbi_pkg::D_WACK;
            end
         end
         lnbi_pkg::D_WACK: begin
            if (fall) begin
               nx.oe = 1'b0;
               nx.state = lnbi_pkg::D_WDAT;
            end
         end
         default: begin
            nx.oe = 1'b0;
            nx.state = lnbi_pkg::D_IDLE;
         end
      endcase
      // start and stop reframe whatever is under way
      if (start) begin
         nx.cnt = 4'h0;
         nx.oe = 1'b0;
         nx.state = lnbi_pkg::D_ADDR;
      end else if (stop) begin
         nx.oe = 1'b0;
         nx.state = lnbi_pkg::D_IDLE;
      end
      // lockout: bus ignored, first two registers cleared
      if (!pg) begin
         nx.oe = 1'b0;
         nx.state = lnbi_pkg::D_IDLE;
         nx.regs[`LNBI_SEL_STATUS1] = 5'h00;
         nx.regs[`LNBI_SEL_TONE1] = 5'h00;
      end
   end
   // state register, all registers zero after reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r <= '0;
         r.state <= lnbi_pkg::D_IDLE;
         r.regs <= `LNBI_REG_RESET;
         r.s1[1:0] <= 2'h3;
         r.s2[1:0] <= 2'h3;
         r.s3[1:0] <= 2'h3;
         r.filt[1:0] <= 2'h3;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
      end else begin
         r <= nx;
      end
   end
   assign sys_cfg = r.regs;
   assign ch1_output_enable = r.regs[`LNBI_SEL_CTL1][`LNBI_EN_BIT];
   assign ch2_output_enable = r.regs[`LNBI_SEL_CTL2][`LNBI_EN_BIT];
   assign interface_ready = r.filt[2];
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = r.oe;
endmodule
`default_nettype wire

/* verilog/lnbi_host.sv */
// bus master end: lite-bus registers drive serial reads and writes
`include "lnbi_map.svh"
`default_nettype none
module lnbi_host #(
   parameter int QTR = `LNBI_QTR_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   lnbi_if.host bus,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq
);
   lnbi_pkg::lnbi_host_type r;
   lnbi_pkg::lnbi_host_type nx;
   logic step;
   logic tx;
   logic [31:0] wm;
   logic [31:0] sm;
   logic [1:0] ev;
   logic [1:0] clr;
   logic busy;
   assign step = (r.tick == 16'(QTR - 1));
   assign tx = r.first | ~r.rd;
   assign busy = (r.state != lnbi_pkg::M_IDLE);
   // write data merged under the byte strobes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wm[8*i +: 8] = r.w_strb[i] ? r.w_data[8*i +: 8] : 8'h00;
         sm[8*i +: 8] = r.w_strb[i] ? 8'hff : 8'h00;
      end
   end
   // serial engine, bus slave and interrupt bits
   always_comb begin
      nx = r;
      ev = 2'h0;
      clr = 2'h0;
      nx.s1 = bus.sda;
      nx.s2 = r.s1;
      nx.s3 = r.s2;
      if (r.s2 == r.s3) begin
         nx.sda_f = r.s2;
      end
      nx.tick = (busy && !step) ? r.tick + 16'h0001 : 16'h0000;
      if (busy && step) begin
         nx.ph = r.ph + 2'h1;
         case (r.state)
            lnbi_pkg::M_START: begin
               if (r.ph == 2'h0) begin
                  nx.sda_oe = 1'b1;
               end else begin
                  nx.scl_oe = 1'b1;
                  nx.ph = 2'h0;
                  nx.state = lnbi_pkg::M_BIT;
               end
            end
            lnbi_pkg::M_BIT: begin
               case (r.ph)
                  2'h0: begin
                     if (r.bitn != 4'h8) begin
                        nx.sda_oe = tx & ~r.shreg[7];
                     end else begin
                        nx.sda_oe = ~tx & (r.byten != r.nbytes);
                     end
                  end
                  2'h1: nx.scl_oe = 1'b0;
                  2'h2: begin
                     if (r.bitn != 4'h8) begin
                        nx.shreg = {r.shreg[6:0], r.sda_f};
                     end else begin
                        nx.ackb = r.sda_f;
                     end
                  end
                  default: begin
                     nx.scl_oe = 1'b1;
                     nx.bitn = r.bitn + 4'h1;
                     if (r.bitn == 4'h8) begin
                        nx.bitn = 4'h0;
                        nx.first = 1'b0;
                        if (tx && r.ackb) begin
                           nx.nack = 1'b1;
                           nx.state = lnbi_pkg::M_STOP;
                        end else if (r.first) begin
                           nx.shreg = r.wdata[7:0];
                        end else begin
                           if (r.rd) begin
                              nx.rdata[{r.byten, 3'h0} +: 8] = r.shreg;
                           end
                           if (r.byten == r.nbytes) begin
                              nx.state = lnbi_pkg::M_STOP;
                           end else begin
                              nx.byten = r.byten + 2'h1;
                              nx.shreg = r.wdata[{nx.byten, 3'h0} +: 8];
                           end
                        end
                     end
                  end
               endcase
            end
            lnbi_pkg::M_STOP: begin
               case (r.ph)
                  2'h0: nx.sda_oe = 1'b1;
                  2'h1: nx.scl_oe = 1'b0;
                  2'h2: nx.sda_oe = 1'b0;
                  default: begin
                     nx.state = lnbi_pkg::M_IDLE;
                     ev = {r.nack, 1'b1};
                  end
               endcase
            end
            default: nx.state = lnbi_pkg::M_IDLE;
         endcase
      end
      // lite-bus address and data channels, taken in either order
      if (awvalid && r.awready) begin
         nx.aw_hold = 1'b1;
         nx.aw_addr = awaddr;
      end
      if (wvalid && r.wready) begin
         nx.w_hold = 1'b1;
         nx.w_data = wdata;
         nx.w_strb = wstrb;
      end
      if (bready && r.bvalid) begin
         nx.bvalid = 1'b0;
      end
      if (r.aw_hold && r.w_hold) begin
         nx.aw_hold = 1'b0;
         nx.w_hold = 1'b0;
         nx.bvalid = 1'b1;
         nx.bresp = `LNBI_RESP_OKAY;
         case (r.aw_addr)
            `LNBI_OFS_CMD: begin
               if (!busy) begin
                  nx.shreg = {wm[6:0], wm[`LNBI_CMD_RD_BIT]};
                  nx.rd = wm[`LNBI_CMD_RD_BIT];
                  nx.nbytes = wm[`LNBI_CMD_CNT_LSB +: 2];
                  nx.first = 1'b1;
                  nx.nack = 1'b0;
                  nx.bitn = 4'h0;
                  nx.byten = 2'h0;
                  nx.ph = 2'h0;
                  nx.state = lnbi_pkg::M_START;
               end
            end
            `LNBI_OFS_WDATA: nx.wdata = (r.wdata & ~sm) | wm;
            `LNBI_OFS_INTEN: nx.int_en = wm[1:0];
            `LNBI_OFS_INTCLR: clr = wm[1:0];
            `LNBI_OFS_RDATA, `LNBI_OFS_STAT, `LNBI_OFS_INTST: ;
            default: nx.bresp = `LNBI_RESP_SLVERR;
         endcase
      end
      if (rready && r.rvalid) begin
         nx.rvalid = 1'b0;
      end
      if (arvalid && r.arready) begin
         nx.rvalid = 1'b1;
         nx.rresp = `LNBI_RESP_OKAY;
         nx.rdat = 32'h0000_0000;
         case (araddr)
            `LNBI_OFS_CMD: ;
            `LNBI_OFS_WDATA: nx.rdat = r.wdata;
            `LNBI_OFS_RDATA: nx.rdat = r.rdata;
            `LNBI_OFS_STAT: nx.rdat = {30'h0000_0000, r.nack, busy};
            `LNBI_OFS_INTST: nx.rdat = {30'h0000_0000, r.int_st};
            `LNBI_OFS_INTEN: nx.rdat = {30'h0000_0000, r.int_en};
            `LNBI_OFS_INTCLR: ;
            default: nx.rresp = `LNBI_RESP_SLVERR;
         endcase
      end
      // sticky events win over a clear in the same cycle
      nx.int_st = (r.int_st & ~clr) | ev;
      nx.irq = |(nx.int_st & nx.int_en);
      nx.awready = ~nx.aw_hold & ~nx.bvalid;
      nx.wready = ~nx.w_hold & ~nx.bvalid;
      nx.arready = ~nx.rvalid;
   end
   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r <= '0;
         r.state <= lnbi_pkg::M_IDLE;
         r.s1 <= 1'b1;
         r.s2 <= 1'b1;
         r.s3 <= 1'b1;
         r.sda_f <= 1'b1;
      end else begin
         r <= nx;
      end
   end
   assign awready = r.awready;
   assign wready = r.wready;
   assign bvalid = r.bvalid;
   assign bresp = r.bresp;
   assign arready = r.arready;
   assign rvalid = r.rvalid;
   assign rdata = r.rdat;
   assign rresp = r.rresp;
   assign irq = r.irq;
   assign bus.host_scl_o = 1'b0;
   assign bus.host_scl_oe = r.scl_oe;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe = r.sda_oe;
endmodule
`default_nettype wire

/* verilog/lnbi_if.sv */
// two-wire bus between host and device, open-drain lines with pull-up
`default_nettype none
interface lnbi_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // wired-and of every enabled driver, released lines read high
   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
      output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

/* verilog/lnbi_map.svh */
// constant map of the supply controller serial interface and its host
`ifndef LNBI_MAP_SVH
`define LNBI_MAP_SVH
// device slave address: fixed upper bits, straps give the low two
`define LNBI_ADDR_UPPER 5'h02
// register selects used by the power-good clearing, live status fields and enable outputs
`define LNBI_SEL_STATUS1 3'h0
`define LNBI_SEL_TONE1 3'h1
`define LNBI_SEL_CTL1 3'h3
`define LNBI_SEL_STATUS2 3'h4
`define LNBI_SEL_TONE2 3'h5
`define LNBI_SEL_CTL2 3'h7
// writable low-five-bit masks, register 7 in the top slice
`define LNBI_WMASK 40'h9f_f809_ff80
`define LNBI_REG_RESET 40'h00_0000_0000
// field positions inside the five data bits of a register
`define LNBI_OVERTEMP_BIT 4
`define LNBI_TONE_BIT 3
`define LNBI_VOLT_BIT 2
`define LNBI_CUR_BIT 1
`define LNBI_TTH_BIT 2
`define LNBI_EN_BIT 4
// inputs passing the pin synchroniser of the device
`define LNBI_NSYNC 14
// timing of the serial clock made by the host
`define LNBI_CLK_PERIOD_NS 25
`define LNBI_SCL_PERIOD_NS 10000
`define LNBI_QTR_CYC ((`LNBI_SCL_PERIOD_NS) / (4 * `LNBI_CLK_PERIOD_NS))
// host register offsets on the lite bus
`define LNBI_OFS_CMD 8'h00
`define LNBI_OFS_WDATA 8'h04
`define LNBI_OFS_RDATA 8'h08
`define LNBI_OFS_STAT 8'h0c
`define LNBI_OFS_INTST 8'h10
`define LNBI_OFS_INTEN 8'h14
`define LNBI_OFS_INTCLR 8'h18
// command fields and lite-bus response codes
`define LNBI_CMD_RD_BIT 7
`define LNBI_CMD_CNT_LSB 8
`define LNBI_RESP_OKAY 2'h0
`define LNBI_RESP_SLVERR 2'h2
`endif

/* verilog/lnbi_pkg.sv */
// types shared by the device end and the host end
`include "lnbi_map.svh"
`default_nettype none
package lnbi_pkg;
   typedef enum logic [6:0] {
      D_IDLE = 7'h01,
      D_ADDR = 7'h02,
      D_AACK = 7'h04,
      D_RDAT = 7'h08,
      D_MACK = 7'h10,
      D_WDAT = 7'h20,
      D_WACK = 7'h40
   } lnbi_dstate_type;
   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_START = 4'h2,
      M_BIT = 4'h4,
      M_STOP = 4'h8
   } lnbi_mstate_type;
   typedef struct packed {
      logic [`LNBI_NSYNC-1:0] s1;
      logic [`LNBI_NSYNC-1:0] s2;
      logic [`LNBI_NSYNC-1:0] s3;
      logic [`LNBI_NSYNC-1:0] filt;
      logic scl_q;
      logic sda_q;
      lnbi_dstate_type state;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [2:0] ptr;
      logic rw;
      logic mack;
      logic oe;
      logic [7:0][4:0] regs;
   } lnbi_dev_type;
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic sda_f;
      lnbi_mstate_type state;
      logic [15:0] tick;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [1:0] byten;
      logic [1:0] nbytes;
      logic rd;
      logic first;
      logic ackb;
      logic nack;
      logic [7:0] shreg;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic scl_oe;
      logic sda_oe;
      logic aw_hold;
      logic [7:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdat;
      logic [1:0] rresp;
      logic [1:0] int_st;
      logic [1:0] int_en;
      logic irq;
   } lnbi_host_type;
endpackage
`default_nettype wire
